// >>> logic/pdi_top.sv
/*
 * pdi_top: MAC-facing data interface in MII, RMII and serial 10 Mbps modes.
 * Line side of the transceiver runs on REF_CLK_I; MAC pins run on the
 * 50 MHz link reference. Assumes the line side feeds one receive nibble
 * at a time and takes transmit nibbles without stalling.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - mii transmit clock is 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps
// - rmii leaves both interface clocks idle, all timing from the 50 MHz reference
// - serial mode drives a 10 MHz transmit clock; MAC launches from it
// - mii transmit nibble is taken on the rising transmit clock
// - rmii transmit dibit is taken on every reference clock edge
// - serial transmit data is taken from line 0 alone on the transmit clock
// - mii receive clock is 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps
// - serial receive clock is 10 MHz
// - mii receive valid marks valid nibbles; its pin strap defaults to mii
// - rmii receive valid is independent of carrier sense
// - serial mode leaves receive valid and receive error low
// - mii at 100 Mbps raises receive error on a bad symbol in a frame
// - rmii at 100 Mbps raises receive error on media error while valid
// - any receive error also corrupts the delivered receive data
// - mii receive nibble changes with the receive clock, valid only with valid
// - rmii receive dibit is driven on the reference clock
// - serial receive data on line 0 only, framed by carrier, upper lines low
// - carrier sense high while the medium is busy, frames serial data
// - mii collision on transmit and receive in half duplex, low in full
module pdi_top
    import pdi_pkg::*;
(
    // core clock and reset
    input  wire logic         REF_CLK_I,
    input  wire logic         RST_I,
    // link reference clock, 50 MHz
    input  wire logic         LINK_CLK_I,
    // straps and link state from the line side
    input  wire logic         SERIAL_MODE_STRAP_I,
    input  wire logic         SPEED_100_I,
    input  wire logic         FULL_DUPLEX_I,
    // line side receive words
    input  wire logic         RX_NIBBLE_VALID_I,
    input  wire logic [3:0]   RX_NIBBLE_I,
    input  wire logic         RX_SYMBOL_ERR_I,
    input  wire logic         RX_CARRIER_I,
    output logic              RX_READY_O,
    // line side transmit words
    output logic              TX_NIBBLE_VALID_O,
    output logic [3:0]        TX_NIBBLE_O,
    output logic              TX_ACTIVE_O,
    output logic              TX_DROP_O,
    output pdi_mode_type      MODE_O,
    // MAC transmit pins
    output logic              TX_CLK_O,
    input  wire logic         TX_EN_I,
    input  wire logic [3:0]   TXD_I,
    // MAC receive pins
    output logic              RX_CLK_O,
    input  wire logic         RX_DV_I,
    output logic              RX_DV_O,
    output logic              RX_DV_OE_O,
    output logic              RX_ER_O,
    output logic [3:0]        RXD_O,
    output logic              CRS_O,
    output logic              COL_O
);
    // -----------------------------------------------------------------
    // core domain: straps and mode
    // -----------------------------------------------------------------
    logic         strap_dv_m;
    logic         strap_dv_s;
    logic         strap_ser_m;
    logic         strap_ser_s;
    pdi_mode_type mode;

    always_ff @(posedge REF_CLK_I) begin
        strap_dv_m  <= RX_DV_I;
        strap_dv_s  <= strap_dv_m;
        strap_ser_m <= SERIAL_MODE_STRAP_I;
        strap_ser_s <= strap_ser_m;
    end

    // mode follows the straps only while reset is held, then stays put
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            if (strap_ser_s == STRAP_SERIAL_LEVEL) begin
                mode <= MODE_SERIAL;
            end else if (strap_dv_s == STRAP_RMII_LEVEL) begin
                mode <= MODE_RMII;
            end else begin
                mode <= MODE_MII;
            end
        end
    end

    assign MODE_O = mode;

    // -----------------------------------------------------------------
    // crossings
    // -----------------------------------------------------------------
    pdi_xfer_if #(.W(TXW_W)) tx_if ();
    pdi_xfer_if #(.W(RXW_W)) rx_if ();
    logic link_rst_m;
    logic link_rst;

    always_ff @(posedge LINK_CLK_I) begin
        link_rst_m <= RST_I;
        link_rst   <= link_rst_m;
    end

    pdi_xfer #(.W(TXW_W)) u_tx_xfer (
        .src_clk_i (LINK_CLK_I),
        .src_rst_i (link_rst),
        .dst_clk_i (REF_CLK_I),
        .dst_rst_i (RST_I),
        .xf        (tx_if)
    );

    pdi_xfer #(.W(RXW_W)) u_rx_xfer (
        .src_clk_i (REF_CLK_I),
        .src_rst_i (RST_I),
        .dst_clk_i (LINK_CLK_I),
        .dst_rst_i (link_rst),
        .xf        (rx_if)
    );

    // -----------------------------------------------------------------
    // core domain: line side words
    // -----------------------------------------------------------------
    logic       tx_act_m;
    logic       tx_act_s;
    logic       drop_m;
    logic       drop_s;
    logic       drop_d;
    logic       tx_en_s;
    logic       drop_tgl;

    assign tx_if.dst_ready = 1'b1;
    assign rx_if.src_valid = RX_NIBBLE_VALID_I;
    assign rx_if.src_data  = {RX_SYMBOL_ERR_I, RX_NIBBLE_I};
    assign RX_READY_O      = rx_if.src_ready;

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            TX_NIBBLE_VALID_O <= 1'b0;
            TX_NIBBLE_O       <= IDLE_NIBBLE;
        end else begin
            TX_NIBBLE_VALID_O <= tx_if.dst_valid;
            if (tx_if.dst_valid) begin
                TX_NIBBLE_O <= tx_if.dst_data;
            end
        end
    end

    // transmit activity level and drop event come over from the link side
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            tx_act_m    <= 1'b0;
            tx_act_s    <= 1'b0;
            drop_m      <= 1'b0;
            drop_s      <= 1'b0;
            drop_d      <= 1'b0;
            TX_ACTIVE_O <= 1'b0;
            TX_DROP_O   <= 1'b0;
        end else begin
            tx_act_m    <= tx_en_s;
            tx_act_s    <= tx_act_m;
            drop_m      <= drop_tgl;
            drop_s      <= drop_m;
            drop_d      <= drop_s;
            TX_ACTIVE_O <= tx_act_s;
            TX_DROP_O   <= drop_s ^ drop_d;
        end
    end

    // -----------------------------------------------------------------
    // link domain: synchronised controls and pins
    // -----------------------------------------------------------------
    pdi_mode_type lmode_m;
    pdi_mode_type lmode;
    logic         spd_m;
    logic         spd;
    logic         fdx_m;
    logic         fdx;
    logic         car_m;
    logic         car;
    logic         tx_en_m;
    logic [3:0]   txd_m;
    logic [3:0]   txd_s;
    logic         is_rmii;
    logic         is_ser;

    always_ff @(posedge LINK_CLK_I) begin
        lmode_m <= mode;
        lmode   <= lmode_m;
        spd_m   <= SPEED_100_I;
        spd     <= spd_m;
        fdx_m   <= FULL_DUPLEX_I;
        fdx     <= fdx_m;
        car_m   <= RX_CARRIER_I;
        car     <= car_m;
        tx_en_m <= TX_EN_I;
        tx_en_s <= tx_en_m;
        txd_m   <= TXD_I;
        txd_s   <= txd_m;
    end

    assign is_rmii = (lmode == MODE_RMII);
    assign is_ser  = (lmode == MODE_SERIAL);

    // -----------------------------------------------------------------
    // link domain: interface clocks
    // -----------------------------------------------------------------
    logic [DIV_W-1:0] div_period;
    logic [DIV_W-1:0] div_high;
    logic             div_clk;
    logic             div_rise;
    logic             div_fall;

    always_comb begin
        unique case (lmode)
            MODE_SERIAL: begin
                div_period = PERIOD_SERIAL;
                div_high   = HIGH_SERIAL;
            end
            default: begin
                div_period = spd ? PERIOD_MII100 : PERIOD_MII10;
                div_high   = spd ? HIGH_MII100 : HIGH_MII10;
            end
        endcase
    end

    // one divider serves both directions; the receive clock is the same divided clock as transmit
    pdi_clkdiv u_div (
        .clk_i    (LINK_CLK_I),
        .rst_i    (link_rst | is_rmii),
        .period_i (div_period),
        .high_i   (div_high),
        .clk_o    (div_clk),
        .rise_o   (div_rise),
        .fall_o   (div_fall)
    );

    assign TX_CLK_O   = div_clk & ~is_rmii;
    assign RX_CLK_O   = div_clk & ~is_rmii;
    assign RX_DV_OE_O = ~link_rst;

    // -----------------------------------------------------------------
    // link domain: transmit assembly
    // -----------------------------------------------------------------
    logic       tx_take;
    logic [3:0] tx_shift;
    logic [1:0] tx_cnt;
    logic [1:0] tx_last;
    logic [3:0] tx_word;

    // rmii samples on every reference edge, the others on the clock we drive
    assign tx_take = is_rmii | div_rise;
    assign tx_last = is_rmii ? LAST_PART_RMII : (is_ser ? LAST_PART_SERIAL : LAST_PART_MII);

    always_comb begin
        unique case (lmode)
            MODE_RMII:   tx_word = {txd_s[1:0], tx_shift[3:2]};
            MODE_SERIAL: tx_word = {txd_s[0], tx_shift[3:1]};
            default:     tx_word = txd_s;
        endcase
    end

    // enable qualifies every part; dropping it mid-nibble discards the parts taken so far
    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            tx_shift <= IDLE_NIBBLE;
            tx_cnt   <= 2'h0;
        end else if (tx_take) begin
            if (!tx_en_s) begin
                tx_cnt <= 2'h0;
            end else begin
                tx_shift <= tx_word;
                tx_cnt   <= (tx_cnt == tx_last) ? 2'h0 : tx_cnt + 2'h1;
            end
        end
    end

    assign tx_if.src_valid = tx_take & tx_en_s & (tx_cnt == tx_last);
    assign tx_if.src_data  = tx_word;

    // no buffer: a nibble that finds the crossing busy is lost and reported
    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            drop_tgl <= 1'b0;
        end else if (tx_if.src_valid && !tx_if.src_ready) begin
            drop_tgl <= ~drop_tgl;
        end
    end

    // -----------------------------------------------------------------
    // link domain: receive delivery
    // -----------------------------------------------------------------
    logic       rx_busy;
    logic [3:0] rx_hold;
    logic       rx_err;
    logic [1:0] rx_cnt;
    logic       rx_adv;
    logic [3:0] rx_data;

    assign rx_adv          = is_rmii | div_fall;
    assign rx_if.dst_ready = ~rx_busy;
    assign rx_data         = rx_err ? (rx_hold ^ CORRUPT_MASK) : rx_hold;

    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            rx_busy <= 1'b0;
            rx_hold <= IDLE_NIBBLE;
            rx_err  <= 1'b0;
            rx_cnt  <= 2'h0;
        end else if (!rx_busy) begin
            if (rx_if.dst_valid) begin
                rx_busy <= 1'b1;
                rx_hold <= rx_if.dst_data[NIB_W-1:0];
                rx_err  <= rx_if.dst_data[RXW_ERR];
                rx_cnt  <= 2'h0;
            end
        end else if (rx_adv) begin
            rx_cnt <= rx_cnt + 2'h1;
            if (rx_cnt == tx_last) begin
                rx_busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            RXD_O   <= IDLE_NIBBLE;
            RX_DV_O <= 1'b0;
            RX_ER_O <= 1'b0;
        end else if (rx_adv) begin
            if (!rx_busy) begin
                RXD_O   <= IDLE_NIBBLE;
                RX_DV_O <= 1'b0;
                RX_ER_O <= 1'b0;
            end else begin
                unique case (lmode)
                    MODE_RMII: begin
                        RXD_O   <= {2'h0, rx_cnt[0] ? rx_data[3:2] : rx_data[1:0]};
                        RX_DV_O <= 1'b1;
                        RX_ER_O <= rx_err & spd;
                    end
                    MODE_SERIAL: begin
                        RXD_O   <= {3'h0, rx_data[rx_cnt]};
                        RX_DV_O <= 1'b0;
                        RX_ER_O <= 1'b0;
                    end
                    default: begin
                        RXD_O   <= rx_data;
                        RX_DV_O <= 1'b1;
                        RX_ER_O <= rx_err & spd;
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // link domain: carrier sense and collision
    // -----------------------------------------------------------------
    always_ff @(posedge LINK_CLK_I) begin
        if (link_rst) begin
            CRS_O <= 1'b0;
            COL_O <= 1'b0;
        end else begin
            // serial carrier must also cover the bits still being shifted out
            CRS_O <= car | rx_busy;
            COL_O <= ~is_rmii & ~fdx & tx_en_s & car;
        end
    end
endmodule : pdi_top

// >>> logic/pdi_pkg.sv
/*
 * pdi_pkg: shared constants and types for the MAC-facing data interface
 * of a 10/100 transceiver: interface modes, divider counts, word layouts.
 * Assumes the link logic runs from a 50 MHz internal reference.
 */
package pdi_pkg;

    // -----------------------------------------------------------------
    // interface modes, latched from the straps
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MII    = 2'b00,
        MODE_RMII   = 2'b01,
        MODE_SERIAL = 2'b10
    } pdi_mode_type;

    // strap levels selecting the reduced mode on the receive-valid pin and serial mode on the serial strap
    localparam logic STRAP_RMII_LEVEL   = 1'b1;
    localparam logic STRAP_SERIAL_LEVEL = 1'b1;

    // -----------------------------------------------------------------
    // clock rates and divider counts
    // -----------------------------------------------------------------
    localparam int LINK_CLK_HZ    = 50_000_000;
    localparam int MII100_CLK_HZ  = 25_000_000;
    localparam int MII10_CLK_HZ   = 2_500_000;
    localparam int SERIAL_CLK_HZ  = 10_000_000;
    localparam int DIV_W          = 5;

    localparam logic [DIV_W-1:0] PERIOD_MII100 = DIV_W'(LINK_CLK_HZ / MII100_CLK_HZ);
    localparam logic [DIV_W-1:0] PERIOD_MII10  = DIV_W'(LINK_CLK_HZ / MII10_CLK_HZ);
    localparam logic [DIV_W-1:0] PERIOD_SERIAL = DIV_W'(LINK_CLK_HZ / SERIAL_CLK_HZ);
    localparam logic [DIV_W-1:0] HIGH_MII100   = DIV_W'(LINK_CLK_HZ / MII100_CLK_HZ / 2);
    localparam logic [DIV_W-1:0] HIGH_MII10    = DIV_W'(LINK_CLK_HZ / MII10_CLK_HZ / 2);
    localparam logic [DIV_W-1:0] HIGH_SERIAL   = DIV_W'(LINK_CLK_HZ / SERIAL_CLK_HZ / 2);

    // -----------------------------------------------------------------
    // word layouts across the clock crossing
    // -----------------------------------------------------------------
    localparam int NIB_W      = 4;
    localparam int TXW_W      = NIB_W;
    localparam int RXW_W      = NIB_W + 1;
    localparam int RXW_ERR    = 4;
    localparam logic [NIB_W-1:0] CORRUPT_MASK = 4'hF;
    localparam logic [NIB_W-1:0] IDLE_NIBBLE  = 4'h0;

    // parts per nibble, minus one, for each mode
    localparam logic [1:0] LAST_PART_MII    = 2'h0;
    localparam logic [1:0] LAST_PART_RMII   = 2'h1;
    localparam logic [1:0] LAST_PART_SERIAL = 2'h3;

endpackage : pdi_pkg

// >>> logic/pdi_xfer_if.sv
/*
 * pdi_xfer_if: valid/ready word carrier across the crossing module.
 * Assumes the src side and dst side each sit in one clock domain.
 */
`timescale 1ns/1ps
interface pdi_xfer_if #(parameter int W = 4);
    logic         src_valid;
    logic         src_ready;
    logic [W-1:0] src_data;
    logic         dst_valid;
    logic         dst_ready;
    logic [W-1:0] dst_data;

    modport src  (output src_valid, output src_data, input src_ready);
    modport xfer (input src_valid, input src_data, output src_ready,
                  output dst_valid, output dst_data, input dst_ready);
    modport dst  (input dst_valid, input dst_data, output dst_ready);
endinterface : pdi_xfer_if

// >>> logic/pdi_xfer.sv
/*
 * pdi_xfer: toggle handshake moving one word at a time between clocks.
 * Assumes src_data is held in a register here until the far side acks.
 */
`timescale 1ns/1ps
module pdi_xfer #(
    parameter int W = 4
) (
    // source domain
    input  wire logic src_clk_i,
    input  wire logic src_rst_i,
    // destination domain
    input  wire logic dst_clk_i,
    input  wire logic dst_rst_i,
    // carrier
    pdi_xfer_if.xfer  xf
);
    logic         req;
    logic         ack_m;
    logic         ack_s;
    logic [W-1:0] hold;
    logic         req_m;
    logic         req_s;
    logic         ack;

    // held word is stable while the request is open, so it crosses as is
    assign xf.src_ready = (req == ack_s);
    assign xf.dst_valid = (req_s != ack);
    assign xf.dst_data  = hold;

    always_ff @(posedge src_clk_i) begin
        if (src_rst_i) begin
            req  <= 1'b0;
            hold <= '0;
        end else if (xf.src_valid && xf.src_ready) begin
            req  <= ~req;
            hold <= xf.src_data;
        end
    end

    always_ff @(posedge src_clk_i) begin
        if (src_rst_i) begin
            ack_m <= 1'b0;
            ack_s <= 1'b0;
        end else begin
            ack_m <= ack;
            ack_s <= ack_m;
        end
    end

    always_ff @(posedge dst_clk_i) begin
        if (dst_rst_i) begin
            req_m <= 1'b0;
            req_s <= 1'b0;
        end else begin
            req_m <= req;
            req_s <= req_m;
        end
    end

    always_ff @(posedge dst_clk_i) begin
        if (dst_rst_i) begin
            ack <= 1'b0;
        end else if (xf.dst_valid && xf.dst_ready) begin
            ack <= ~ack;
        end
    end
endmodule : pdi_xfer

// >>> logic/pdi_clkdiv.sv
/*
 * pdi_clkdiv: programmable divider making the interface clocks.
 * Assumes period_i >= 2 and high_i below period_i, static outside reset.
 */
`timescale 1ns/1ps
module pdi_clkdiv
    import pdi_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // shape
    input  wire logic [DIV_W-1:0] period_i,
    input  wire logic [DIV_W-1:0] high_i,
    // divided clock and its edges
    output logic                  clk_o,
    output logic                  rise_o,
    output logic                  fall_o
);
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;

    assign next_cnt = (cnt == period_i - 1'b1) ? '0 : cnt + 1'b1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // all ones wraps to zero, so the first high phase is full length
            cnt <= '1;
        end else begin
            cnt <= next_cnt;
        end
    end

    // fall_o marks the edge at which clk_o drops: data launched there settles
    // for the low phase, period_i minus high_i cycles, before the far side samples it on the rise
    assign fall_o = ~rst_i & (next_cnt == high_i);

    // rise_o coincides with the cycle in which clk_o has just risen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_o  <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            clk_o  <= (next_cnt < high_i);
            rise_o <= (next_cnt == '0);
        end
    end
endmodule : pdi_clkdiv

// >>> testbench/pdi_top_sva.sv
/* pdi_top_sva: pin timing checks bound to pdi_top.
   assumes speed, duplex and straps stay static outside reset */
`timescale 1ns/1ps
module pdi_top_sva
    import pdi_pkg::*;
(
    // clocks, reset and static inputs
    input wire logic         REF_CLK_I,
    input wire logic         LINK_CLK_I,
    input wire logic         RST_I,
    input wire logic         SPEED_100_I,
    input wire logic         FULL_DUPLEX_I,
    input wire pdi_mode_type MODE_O,
    // mac pins
    input wire logic         TX_CLK_O,
    input wire logic         RX_CLK_O,
    input wire logic         RX_DV_O,
    input wire logic         RX_ER_O,
    input wire logic [3:0]   RXD_O,
    input wire logic         COL_O
);
    default clocking @(posedge LINK_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic mii = (MODE_O == MODE_MII);
    wire logic ser = (MODE_O == MODE_SERIAL);
    a_mii_slow_clk: assert property (mii && !SPEED_100_I && $rose(TX_CLK_O)
        |-> TX_CLK_O[*8] ##1 TX_CLK_O[*2] ##1 !TX_CLK_O) else $error("slow clock shape wrong");
    a_mii_fast_clk: assert property (mii && SPEED_100_I && $rose(TX_CLK_O)
        |=> !TX_CLK_O ##1 TX_CLK_O) else $error("fast clock shape wrong");
    a_serial_clk: assert property (ser && $rose(TX_CLK_O)
        |=> TX_CLK_O ##1 !TX_CLK_O[*3] ##1 TX_CLK_O) else $error("serial clock shape wrong");
    a_rx_tx_clk: assert property (RX_CLK_O == TX_CLK_O) else $error("receive clock differs");
    a_rmii_clk_idle: assert property (MODE_O == MODE_RMII |-> !TX_CLK_O && !RX_CLK_O)
        else $error("clock runs in reduced mode");
    a_serial_quiet: assert property (ser |-> !RX_DV_O && !RX_ER_O && RXD_O[3:1] == 3'h0)
        else $error("serial mode drives unused lines");
    a_idle_quiet: assert property (!ser && !RX_DV_O |-> RXD_O == 4'h0 && !RX_ER_O)
        else $error("idle receive lines not quiet");
    a_err_cause: assert property (RX_ER_O |-> RX_DV_O && SPEED_100_I && !ser)
        else $error("receive error without cause");
    a_full_dup_col: assert property (FULL_DUPLEX_I |-> !COL_O) else $error("collision in full duplex");
    a_mode_fixed: assert property (!$past(RST_I) |-> $stable(MODE_O)) else $error("mode changed");
endmodule : pdi_top_sva
bind pdi_top pdi_top_sva u_sva (.REF_CLK_I, .LINK_CLK_I, .RST_I, .SPEED_100_I, .FULL_DUPLEX_I, .MODE_O,
    .TX_CLK_O, .RX_CLK_O, .RX_DV_O, .RX_ER_O, .RXD_O, .COL_O);

// >>> testbench/pdi_mac_model.sv
/* pdi_mac_model: mac at the data pins; transmit queue filled by the bench, receive queue from the pins.
   assumes mii or serial mode, launching on the rising transmit clock */
`timescale 1ns/1ps
module pdi_mac_model
    import pdi_pkg::*;
(
    // clocks and mode
    input  wire logic         tx_clk_i,
    input  wire logic         rx_clk_i,
    input  wire pdi_mode_type mode_i,
    // receive pins
    input  wire logic         rx_dv_i,
    input  wire logic         rx_er_i,
    input  wire logic [3:0]   rxd_i,
    // transmit pins
    output logic              tx_en_o = 1'b0,
    output logic [3:0]        txd_o = 4'h5
);
    logic [3:0] txq[$];
    logic [4:0] rxq[$];
    logic [3:0] cur;
    int         bc = 0;
    always @(posedge tx_clk_i) begin
        if (bc == 0 && txq.size() > 0) begin
            cur = txq.pop_front();
            bc = (mode_i == MODE_SERIAL) ? 4 : 1;
        end
        if (bc > 0) begin
            tx_en_o <= 1'b1;
            txd_o <= (mode_i == MODE_SERIAL) ? {~txd_o[3:1], cur[4-bc]} : cur;
            bc--;
        end else begin
            tx_en_o <= 1'b0;
            // released lines toggle so stale data never passes for valid
            txd_o <= ~txd_o;
        end
    end
    always @(posedge rx_clk_i) begin
        if (rx_dv_i && mode_i == MODE_MII) rxq.push_back({rx_er_i, rxd_i});
    end
endmodule : pdi_mac_model

// >>> testbench/testbench.sv
/* testbench: pdi_top under mii 10M, mii 100M, serial and reduced straps.
   assumes the mac model on the pins; link clock 32 ns, free phase */
`timescale 1ns/1ps
module testbench;
    import pdi_pkg::*;
    logic         REF_CLK_I = 1'b0, LINK_CLK_I = 1'b0, RST_I = 1'b1, rmii_strap = 1'b0;
    logic         SERIAL_MODE_STRAP_I = 1'b0, SPEED_100_I = 1'b0, FULL_DUPLEX_I = 1'b1;
    logic         RX_NIBBLE_VALID_I = 1'b0, RX_SYMBOL_ERR_I = 1'b0, RX_CARRIER_I = 1'b0;
    logic         RX_READY_O, TX_NIBBLE_VALID_O, TX_ACTIVE_O, TX_DROP_O, TX_CLK_O, TX_EN_I;
    logic         RX_CLK_O, RX_DV_O, RX_DV_OE_O, RX_ER_O, CRS_O, COL_O, tx_act;
    logic [3:0]   RX_NIBBLE_I = 4'h0, TX_NIBBLE_O, TXD_I, RXD_O;
    pdi_mode_type MODE_O;
    wire logic    RX_DV_I = RX_DV_OE_O ? RX_DV_O : rmii_strap;
    int           n_fail = 0, n_tests = 0, drops = 0, cols = 0;
    logic [31:0]  seed = 32'h0000302B;
    logic [3:0]   txgot[$];
    pdi_top dut (.*);
    pdi_mac_model mac (.tx_clk_i(TX_CLK_O), .rx_clk_i(RX_CLK_O), .mode_i(MODE_O), .rx_dv_i(RX_DV_O),
        .rx_er_i(RX_ER_O), .rxd_i(RXD_O), .tx_en_o(TX_EN_I), .txd_o(TXD_I));
    initial forever #5 REF_CLK_I = ~REF_CLK_I;
    initial begin
        #3.7;
        forever #16 LINK_CLK_I = ~LINK_CLK_I;
    end
    always @(posedge REF_CLK_I) begin
        if (TX_NIBBLE_VALID_O === 1'b1 && txgot.size() == 0) tx_act = TX_ACTIVE_O;
        if (TX_NIBBLE_VALID_O === 1'b1) txgot.push_back(TX_NIBBLE_O);
        if (TX_DROP_O === 1'b1) drops++;
        if (COL_O === 1'b1) cols++;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [4:0] exp_rx(logic [3:0] n, logic e);
        return e ? {SPEED_100_I, n ^ 4'hF} : {1'b0, n};
    endfunction : exp_rx
    task automatic check(string what, logic [4:0] e, logic [4:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic final_report();
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic wait_len(int n, bit rx);
        for (int k = 0; k < 20000; k++) begin
            @(posedge REF_CLK_I);
            if ((rx ? mac.rxq.size() : txgot.size()) >= n) return;
        end
        n_fail++;
        final_report();
    endtask : wait_len
    task automatic rx_send(logic [3:0] n, logic e);
        int k;
        @(posedge REF_CLK_I);
        RX_NIBBLE_VALID_I <= 1'b1;
        RX_NIBBLE_I <= n;
        RX_SYMBOL_ERR_I <= e;
        for (k = 0; k < 500; k++) begin
            @(negedge REF_CLK_I);
            if (RX_READY_O === 1'b1) break;
        end
        @(posedge REF_CLK_I);
        RX_NIBBLE_VALID_I <= 1'b0;
        if (k >= 500) wait_len(1 << 30, 1'b1);
    endtask : rx_send
    initial begin
        logic [3:0]   nib[8];
        logic         err[8];
        static pdi_mode_type want[4] = '{MODE_MII, MODE_MII, MODE_SERIAL, MODE_RMII};
        for (int c = 0; c < 4; c++) begin
            @(posedge REF_CLK_I);
            RST_I <= 1'b1;
            SERIAL_MODE_STRAP_I <= (c == 2);
            rmii_strap <= (c == 3);
            SPEED_100_I <= (c == 1);
            FULL_DUPLEX_I <= (c == 2);
            repeat (20) @(posedge REF_CLK_I);
            RST_I <= 1'b0;
            repeat (20) @(posedge REF_CLK_I);
            check("mode", {3'h0, want[c]}, {3'h0, MODE_O});
            if (c == 3) break;
            txgot.delete();
            cols = 0;
            mac.rxq.delete();
            // corners: all-zero and all-one nibbles, error on the last
            foreach (nib[i]) nib[i] = (i < 2) ? {4{i[0]}} : 4'(rnd());
            foreach (err[i]) err[i] = (i == 7) || (rnd() % 4 == 0);
            // transmit overlaps the receive burst so half duplex shows a collision
            if (c != 1) foreach (nib[i]) mac.txq.push_back(nib[i]);
            if (c < 2) begin
                RX_CARRIER_I <= 1'b1;
                foreach (nib[i]) rx_send(nib[i], err[i]);
                check("carrier", 5'h01, {4'h0, CRS_O});
                RX_CARRIER_I <= 1'b0;
                wait_len(8, 1'b1);
                check("carrier", 5'h00, {4'h0, CRS_O});
                foreach (nib[i]) check("rx nibble", exp_rx(nib[i], err[i]), mac.rxq[i]);
                check("collision", {4'h0, c == 0}, {4'h0, cols > 0});
            end
            if (c != 1) begin
                wait_len(8, 1'b0);
                foreach (nib[i]) check("tx nibble", {1'b0, nib[i]}, {1'b0, txgot[i]});
                check("tx drops", 5'h00, 5'(drops));
                check("tx active", 5'h01, {4'h0, tx_act});
            end
        end
        final_report();
    end
endmodule : testbench
